// *** rtl/vrc_pkg.sv ***
// Purpose: constants and carrier types for the video dram random port controller
// Assumes: 100 MHz ref_clk, one clock domain
// Notes:   times are in ns as printed, refresh period in us, cycle counts derive from them
package vrc_pkg;
  localparam int CLK_NS          = 10;                         // ref_clk period
  localparam int ADDR_W          = 16;                         // word address width
  localparam int MUX_W           = 8;                          // shared address pins
  localparam int DATA_W          = 8;                          // word width
  localparam int ROWS            = 256;                        // rows to refresh
  // timing in ns, slowest grade figures
  localparam int T_RP_NS         = 70;                         // row_precharge_time
  localparam int T_RAS_NS        = 100;                        // row_strobe_min_width
  localparam int T_CAS_NS        = 25;                         // column_strobe_min_width
  localparam int T_RAH_NS        = 15;                         // row address hold
  localparam int T_RAC_NS        = 100;                        // access_from_row_strobe
  localparam int T_CAC_NS        = 25;                         // access_from_column_strobe
  localparam int T_OEA_NS        = 25;                         // access_from_output_enable
  localparam int T_CP_NS         = 15;                         // page column precharge
  localparam int T_CSR_NS        = 10;                         // cbr column setup
  localparam int T_REF_US        = 4000;                       // refresh period, 4 ms
  // cycle counts, least times rounded up
  localparam int C_RP  = (T_RP_NS  + CLK_NS - 1) / CLK_NS;
  localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CAS = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAH = (T_RAH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_ACC = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_OEA = (T_OEA_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CP  = (T_CP_NS  + CLK_NS - 1) / CLK_NS;
  localparam int C_CSR = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
  // interval between distributed refreshes, longest time rounds down
  localparam int C_REF_GAP = (T_REF_US * 1000 / CLK_NS) / ROWS;
  localparam int CNT_W = 8;                                    // timer width

  // command encoding
  typedef enum logic [1:0] {
    VRC_OP_READ  = 2'b00,
    VRC_OP_WRITE = 2'b01,
    VRC_OP_RMW   = 2'b10
  } vrc_op_t;

  // request from user
  typedef struct packed {
    vrc_op_t             op;     // access kind
    logic [ADDR_W-1:0]   addr;   // row in upper byte, column in lower
    logic [DATA_W-1:0]   wdata;  // write data
    logic                masked; // use write mask
    logic [DATA_W-1:0]   mask;   // 1 = bit is written
    logic                page;   // keep row open for next same-row request
  } vrc_req_t;

  // pins toward the memory
  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              write_mask_select_n;
    logic              transfer_output_enable_n;
    logic [MUX_W-1:0]  addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } vrc_pins_t;
endpackage : vrc_pkg

// *** rtl/vrc_ctrl.sv ***
// Purpose: host controller for the random port of a 64K x 8 dual-port video dram
// Assumes: dq input synchronous to ref_clk; one request at a time
// Notes:   refresh is distributed cas-before-ras, one row per interval
// Function
// RL1: memory holds 64K eight-bit words
// RL2: row byte then column byte on pins
// RL3: row strobe first, then column address, cas
// RL4: both strobes high ends cycle; precharge
// RL5: never abort before minimum strobe widths
// RL6: write enable high throughout means read
// RL7: access timed from row strobe normally
// RL8: data only while output enable low
// RL9: early write keeps outputs high impedance
// RL10: late write gives read-modify-write
// RL11: read holds write enable after strobes
// RL12: write data valid by later falling edge
// RL13: page mode: row held, columns repeat
// RL14: write enable low at ras latches mask
// RL15: mask zero blocks, one allows bit
// RL16: mask valid for one cycle only
// RL17: strobes and output enable high at power-up
// RL18: device data pins high impedance after power-up
// RL19: outputs off while cas or oe high
// RL20: refresh all 256 rows every 4 ms
// RL21: cas before ras refreshes counter row
`timescale 1ns/100ps
module vrc_ctrl #(
  parameter int REF_GAP = vrc_pkg::C_REF_GAP  // cycles between refresh rows
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire vrc_pkg::vrc_req_t                req,
  input  wire logic                             req_valid,
  output logic                                  req_ready,
  output logic [vrc_pkg::DATA_W-1:0]            rdata,
  output logic                                  rdata_valid,
  output vrc_pkg::vrc_pins_t                    pins,
  input  wire logic [vrc_pkg::DATA_W-1:0]       dq_in
);
  // controller states
  typedef enum logic [3:0] {
    S_INIT   = 4'b0000,  // power-up precharge
    S_IDLE   = 4'b0001,
    S_ROW    = 4'b0010,  // ras low, row address held
    S_COL    = 4'b0011,  // column address set up
    S_CAS    = 4'b0100,  // cas low, access
    S_WLATE  = 4'b0101,  // rmw: late write enable
    S_CUP    = 4'b0110,  // cas high, page precharge
    S_PRE    = 4'b0111,  // ras precharge
    S_CBR    = 4'b1000,  // cbr: cas low before ras
    S_CBR_R  = 4'b1001   // cbr: ras low
  } vrc_state_t;

  vrc_state_t            state_r;        // current state
  vrc_pkg::vrc_req_t     cur_r;          // active request
  logic [vrc_pkg::CNT_W-1:0] tmr_r;      // state timer
  logic [vrc_pkg::CNT_W-1:0] ras_tmr_r;  // cycles since ras fell
  logic [31:0]           ref_cnt_r;      // refresh interval counter
  logic                  ref_due_r;      // refresh pending
  logic                  wrote_r;        // write phase of rmw done
  logic                  page_hit;       // next request stays in open row

  // a page continues only with same row and page asked for; a mask is
  // latched only at the row strobe fall, so masked work never joins a page
  assign page_hit  = req_valid && cur_r.page && !cur_r.masked && !req.masked &&
                     (req.addr[15:8] == cur_r.addr[15:8]) && !ref_due_r; // RL13
  assign req_ready = (state_r == S_IDLE && !ref_due_r) ||
                     (state_r == S_CUP && tmr_r == '0 && page_hit);

  // refresh interval timer, sets pending flag, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_cnt_r <= '0;
      ref_due_r <= 1'b0;
    end else begin
      if (ref_cnt_r == 32'(REF_GAP - 1)) begin
        ref_cnt_r <= '0;
        ref_due_r <= 1'b1;                        // RL20
      end else begin
        ref_cnt_r <= ref_cnt_r + 32'd1;
        if (state_r == S_CBR) ref_due_r <= 1'b0;
      end
    end
  end

  // time since ras fell, guards the minimum row strobe width
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ras_tmr_r <= '0;
    end else if (pins.ras_n) begin
      ras_tmr_r <= '0;
    end else if (ras_tmr_r != '1) begin
      ras_tmr_r <= ras_tmr_r + 1'b1;
    end
  end

  // main sequencer driving the pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r     <= S_INIT;
      tmr_r       <= vrc_pkg::CNT_W'(vrc_pkg::C_RP);
      cur_r       <= '0;
      wrote_r     <= 1'b0;
      rdata       <= '0;
      rdata_valid <= 1'b0;
      pins.ras_n  <= 1'b1;                        // RL17
      pins.cas_n  <= 1'b1;
      pins.write_mask_select_n      <= 1'b1;
      pins.transfer_output_enable_n <= 1'b1;      // RL17
      pins.addr   <= '0;
      pins.dq_out <= '0;
      pins.dq_oe  <= 1'b0;                        // RL18
    end else begin
      rdata_valid <= 1'b0;
      if (tmr_r != '0) tmr_r <= tmr_r - 1'b1;
      unique case (state_r)
        // hold strobes, write enable and output enable high through the first precharge
        S_INIT: begin
          if (tmr_r == '0) state_r <= S_IDLE;
        end
        // pick refresh first, then a request
        S_IDLE: begin
          if (ref_due_r) begin
            pins.cas_n <= 1'b0;                   // RL21
            tmr_r      <= vrc_pkg::CNT_W'(vrc_pkg::C_CSR);
            state_r    <= S_CBR;
          end else if (req_valid) begin
            cur_r      <= req;
            pins.addr  <= req.addr[15:8];         // RL2
            pins.ras_n <= 1'b0;                   // RL3
            // write enable low at ras selects masked write
            pins.write_mask_select_n <= !(req.masked && req.op != vrc_pkg::VRC_OP_READ); // RL14
            pins.dq_out <= req.mask;              // RL15
            pins.dq_oe  <= req.masked && req.op != vrc_pkg::VRC_OP_READ;
            tmr_r      <= vrc_pkg::CNT_W'(vrc_pkg::C_RAH);
            state_r    <= S_ROW;
          end
        end
        // after row hold, present column and data
        S_ROW: begin
          if (tmr_r == '0) begin
            pins.addr   <= cur_r.addr[7:0];       // RL3
            pins.dq_oe  <= 1'b0;
            pins.write_mask_select_n <= 1'b1;     // RL6
            if (cur_r.op == vrc_pkg::VRC_OP_WRITE) begin
              pins.dq_out <= cur_r.wdata;         // RL12
              pins.dq_oe  <= 1'b1;
              pins.write_mask_select_n <= 1'b0;   // RL9
            end else begin
              pins.transfer_output_enable_n <= 1'b0; // RL8
            end
            state_r <= S_COL;
          end
        end
        // column strobe; timer covers access, cas width and oe access
        S_COL: begin
          pins.cas_n <= 1'b0;                     // RL3
          tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_ACC > vrc_pkg::C_CAS + vrc_pkg::C_OEA ?
                     vrc_pkg::C_ACC : vrc_pkg::C_CAS + vrc_pkg::C_OEA); // RL7
          wrote_r <= 1'b0;
          state_r <= S_CAS;
        end
        // wait access; sample read data, rmw goes on to late write
        S_CAS: begin
          if (tmr_r == '0 && ras_tmr_r >= vrc_pkg::CNT_W'(vrc_pkg::C_RAS)) begin // RL5
            if (cur_r.op != vrc_pkg::VRC_OP_WRITE) begin
              rdata       <= dq_in;
              rdata_valid <= 1'b1;
            end
            if (cur_r.op == vrc_pkg::VRC_OP_RMW) begin
              pins.transfer_output_enable_n <= 1'b1;  // RL19
              pins.dq_out <= cur_r.wdata;
              tmr_r   <= 8'd1;
              state_r <= S_WLATE;                 // RL10
            end else begin
              // write enable stays high past cas rise on reads
              pins.cas_n <= 1'b1;                 // RL11
              pins.transfer_output_enable_n <= 1'b1;
              pins.dq_oe <= 1'b0;
              pins.write_mask_select_n <= 1'b1;
              tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_CP);
              state_r <= S_CUP;
            end
          end
        end
        // once outputs turn off, drive data and pulse write enable together
        S_WLATE: begin
          if (!wrote_r && tmr_r == '0) begin
            pins.dq_oe <= 1'b1;
            pins.write_mask_select_n <= 1'b0;     // RL12
            tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_CAS);
            wrote_r <= 1'b1;
          end else if (wrote_r && tmr_r == '0) begin
            pins.cas_n <= 1'b1;
            pins.dq_oe <= 1'b0;
            pins.write_mask_select_n <= 1'b1;
            tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_CP);
            state_r <= S_CUP;
          end
        end
        // cas precharged; continue the page or close the row
        S_CUP: begin
          if (tmr_r == '0) begin
            if (page_hit && !cur_r.masked) begin
              cur_r     <= req;
              cur_r.masked <= 1'b0;               // RL16
              pins.addr <= req.addr[7:0];         // RL13
              if (req.op == vrc_pkg::VRC_OP_WRITE) begin
                pins.dq_out <= req.wdata;
                pins.dq_oe  <= 1'b1;
                pins.write_mask_select_n <= 1'b0;
              end else begin
                pins.transfer_output_enable_n <= 1'b0;
              end
              state_r <= S_COL;
            end else begin
              pins.ras_n <= 1'b1;                 // RL4
              tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_RP);
              state_r <= S_PRE;
            end
          end
        end
        // row precharge before anything new
        S_PRE: begin
          if (tmr_r == '0) state_r <= S_IDLE;     // RL4
        end
        // cas setup before ras in refresh
        S_CBR: begin
          if (tmr_r == '0) begin
            pins.ras_n <= 1'b0;                   // RL21
            tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_RAS);
            state_r <= S_CBR_R;
          end
        end
        // hold ras minimum width, then release both strobes
        S_CBR_R: begin
          if (tmr_r == '0) begin
            pins.ras_n <= 1'b1;                   // RL5
            pins.cas_n <= 1'b1;
            tmr_r   <= vrc_pkg::CNT_W'(vrc_pkg::C_RP);
            state_r <= S_PRE;
          end
        end
        default: state_r <= S_INIT;
      endcase
    end
  end
endmodule : vrc_ctrl

// *** sim/vrc_ctrl_assertions.sv ***
// Purpose: pin timing checks for vrc_ctrl
// Assumes: one clock domain, rst async high
// Notes:   figures are the package cycle counts
`timescale 1ns/100ps
module vrc_ctrl_assertions #(
  parameter int REF_GAP = vrc_pkg::C_REF_GAP  // cycles between refresh rows
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire vrc_pkg::vrc_req_t  req,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire vrc_pkg::vrc_pins_t pins
);
  logic [7:0]  col_r;    // column of the last taken request
  logic [15:0] run_r;    // samples spent at the present row strobe level
  logic [15:0] ref_r;    // cycles since the last refresh start
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // remember the column that the next column strobe must carry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) col_r <= 8'h00;
    else if (req_valid && req_ready) col_r <= req.addr[7:0];
  end
  // length of each row strobe level, restarts on every change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) run_r <= 16'h0000;
    else if ($changed(pins.ras_n)) run_r <= 16'h0001;
    else run_r <= run_r + 16'h0001;
  end
  // refresh distance, restarts when column strobe leads row strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) ref_r <= 16'h0000;
    else if ($fell(pins.ras_n) && !pins.cas_n) ref_r <= 16'h0000;
    else ref_r <= ref_r + 16'h0001;
  end
  sequence s_take;
    req_valid && req_ready && pins.ras_n;
  endsequence
  sequence s_row_out;
    $fell(pins.ras_n) && pins.addr == $past(req.addr[15:8]);
  endsequence
  property p_row_first;
    s_take |=> s_row_out;
  endproperty
  a_row_first: assert property (p_row_first) else $error("row address not first");
  property p_col_addr;
    $fell(pins.cas_n) && !pins.ras_n |-> pins.addr == col_r;
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("wrong column address");
  property p_ras_width;
    $rose(pins.ras_n) |-> run_r >= 16'(vrc_pkg::C_RAS);
  endproperty
  a_ras_width: assert property (p_ras_width) else $error("row strobe too short");
  property p_precharge;
    $fell(pins.ras_n) |-> run_r >= 16'(vrc_pkg::C_RP);
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short");
  property p_cas_width;
    $fell(pins.cas_n) && !pins.ras_n |-> !pins.cas_n [*3];
  endproperty
  a_cas_width: assert property (p_cas_width) else $error("column strobe too short");
  property p_reset_idle;
    $fell(rst) |-> pins.ras_n && pins.transfer_output_enable_n && !pins.dq_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle at reset");
  property p_read_we;
    !pins.cas_n && !pins.transfer_output_enable_n |-> pins.write_mask_select_n;
  endproperty
  a_read_we: assert property (p_read_we) else $error("write enable low in read");
  property p_wr_data;
    !pins.ras_n && !pins.cas_n && !pins.write_mask_select_n |-> pins.dq_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not driven");
  property p_no_clash;
    pins.dq_oe |-> pins.transfer_output_enable_n;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives while enabled");
  property p_ref_gap;
    ref_r < 16'(REF_GAP + 64);
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh interval exceeded");
endmodule : vrc_ctrl_assertions

bind vrc_ctrl vrc_ctrl_assertions #(.REF_GAP(REF_GAP)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .pins(pins));

// *** sim/vrc_dram_model.sv ***
// Purpose: behavioural random port of the video dram
// Assumes: pins sampled on ref_clk rising edges
// Notes:   undriven data lines toggle instead of holding
`timescale 1ns/100ps
module vrc_dram_model (
  input wire logic               ref_clk,
  input wire vrc_pkg::vrc_pins_t pins,
  output logic [7:0]             dq_in
);
  logic [7:0]  mem [65536];        // 64K eight-bit words
  logic [7:0]  row_r = 8'h00;      // open row
  logic [7:0]  col_r = 8'h00;      // last column
  logic [7:0]  mask_r = 8'h00;     // write_mask_register
  logic [7:0]  ref_row_r = 8'h00;  // internal refresh row counter
  logic        mask_en_r = 1'b0;   // masked writing armed
  logic        ras_q = 1'b1;       // previous row strobe
  logic        cas_q = 1'b1;       // previous column strobe
  logic        we_q = 1'b1;        // previous write enable
  logic [15:0] wa;                 // write address
  initial dq_in = 8'h5a;           // not driving after power-up
  // strobe decoding, writes and read data
  always @(posedge ref_clk) begin
    wa = {row_r, (cas_q ? pins.addr : col_r)};
    if (ras_q && !pins.ras_n && pins.cas_n) begin
      row_r <= pins.addr;
      mask_en_r <= !pins.write_mask_select_n;
      mask_r <= pins.dq_out;
    end
    if (ras_q && !pins.ras_n && !pins.cas_n) ref_row_r <= ref_row_r + 8'h01;
    if (!ras_q && pins.ras_n) mask_en_r <= 1'b0;
    if (cas_q && !pins.cas_n && !pins.ras_n) col_r <= pins.addr;
    if (!pins.ras_n && !pins.cas_n && !pins.write_mask_select_n && (cas_q || we_q)) begin
      mem[wa] <= mask_en_r ? (mem[wa] & ~mask_r) | (pins.dq_out & mask_r) : pins.dq_out;
    end
    if (!cas_q && !pins.cas_n && !pins.transfer_output_enable_n) dq_in <= mem[{row_r, col_r}];
    else dq_in <= ~dq_in;
    ras_q <= pins.ras_n;
    cas_q <= pins.cas_n;
    we_q <= pins.write_mask_select_n;
  end
endmodule : vrc_dram_model

// *** sim/vrc_ctrl_tb.sv ***
// Purpose: self-checking bench for vrc_ctrl
// Assumes: in-order answers, shadow memory predicts reads
// Notes:   refresh interval shortened to 200 cycles
`timescale 1ns/100ps
module vrc_ctrl_tb;
  localparam int GAP = 200;          // shortened refresh interval
  logic               ref_clk = 1'b0;
  logic               rst = 1'b1;
  vrc_pkg::vrc_req_t  req = '0;
  logic               req_valid = 1'b0;
  logic               req_ready, rdata_valid;
  logic [7:0]         rdata, dq_in;
  vrc_pkg::vrc_pins_t pins;
  logic [7:0]         shadow [65536];  // expected memory contents
  logic [7:0]         exp_q [$];       // expected read data in order
  int                 n_fail = 0;
  int                 num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  vrc_ctrl #(.REF_GAP(GAP)) uut (.ref_clk(ref_clk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
    .rdata_valid(rdata_valid), .pins(pins), .dq_in(dq_in));
  vrc_dram_model u_mem (.ref_clk(ref_clk), .pins(pins), .dq_in(dq_in));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic check_rd(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR rdata expected %h seen %h", e, g);
    end
  endtask : check_rd
  // hand one request over, then note its effect
  task automatic send(input vrc_pkg::vrc_req_t r);
    int n;
    logic [7:0] old;
    old = shadow[r.addr];
    req <= r;
    req_valid <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(negedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge ref_clk);
    if (n == 400) begin
      n_fail++;
      $display("ERROR req_ready expected 1 seen 0");
      give_verdict();
    end else begin
      if (r.op != vrc_pkg::VRC_OP_READ)
        shadow[r.addr] = r.masked ? (old & ~r.mask) | (r.wdata & r.mask) : r.wdata;
      if (r.op != vrc_pkg::VRC_OP_WRITE) exp_q.push_back(old);
    end
  endtask : send
  function automatic vrc_pkg::vrc_req_t rnd_req(input logic [7:0] row);
    vrc_pkg::vrc_req_t r;
    r.op = vrc_pkg::vrc_op_t'($urandom_range(2, 0));
    r.addr = {row, 6'h00, 2'($urandom_range(3, 0))};
    r.wdata = 8'($urandom);
    r.masked = (r.op != vrc_pkg::VRC_OP_READ) && 1'($urandom);
    r.mask = 8'($urandom);
    r.page = 1'($urandom);
    return r;
  endfunction : rnd_req
  // answers are taken off the queue in order
  always @(negedge ref_clk) begin
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("ERROR rdata expected none seen %h", rdata);
      end
      else check_rd(exp_q.pop_front(), rdata);
    end
  end
  initial begin
    vrc_pkg::vrc_req_t r;
    int n;
    void'($urandom(77748));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (n = 0; n < 8; n++) begin
      r = rnd_req(8'(n / 4));
      r.op = vrc_pkg::VRC_OP_WRITE;
      r.masked = 1'b0;
      r.addr[1:0] = 2'(n);
      send(r);
    end
    $display("test fill done");
    for (n = 0; n < 120; n++) send(rnd_req(8'($urandom_range(1, 0))));
    $display("test mixed done");
    for (n = 0; n < 24; n++) begin
      r = rnd_req(8'h01);
      r.masked = 1'b0;
      r.page = 1'b1;
      send(r);
    end
    $display("test page done");
    req_valid <= 1'b0;
    for (n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge ref_clk);
    if (exp_q.size() > 0) begin
      n_fail++;
      $display("ERROR pending reads expected 0 seen %0d", exp_q.size());
    end
    give_verdict();
  end
endmodule : vrc_ctrl_tb
